// file: core/ddf_flag_bank.sv
/*
 digital fault flag register and readback selection.
 holds the sticky fault flags, the self-clearing refresh and slew flags,
 the fault pin status and the register address of the readback word.
 assumes: the serial front end decodes frames and presents a one-cycle
 write strobe with data for this register, plus the selection code.
 the refresh and slew engines report their activity on level inputs,
 and the fault pin level comes in already synchronised.
 the readback word is registered, so it follows a new selection code
 one clock later; reserved codes are not refused here, only flagged,
 and they still return the other register with the code in bits 20:16.
 the flag word itself is combinational, so the live bits follow their
 inputs in the same cycle.
*/
// Functional notes
// - codes 0x05..0x18 and 0x1C select registers; 0x19..0x1B are never used.
// - after reset the flag register reads 0x14A000 while the fault pin is high and the output does not slew.
// - sticky flags hold until a written one updates them to their condition.
// - refresh and slew flags clear by themselves when their activity ends.
// - a flag whose enable is off reads as zero.
// - bit 21 shows the inverted level of the fault pin.
// - bit 15 is one while a refresh is pending and one after power-up.
// - a write changing the range bits starts a refresh and sets bit 15.
// - bit 14 is one while the output slews.
// - bit 13 is set by any reset and held until a written one.
// - bit 12 latches an interdie link error.
// - bit 11 latches a watchdog timeout.
// - bit 9 latches a parity error when read-and-compare is enabled.
// - bit 8 latches a latch mismatch.
`timescale 1ns/1ns
module ddf_flag_bank
	import ddf_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// register write strobe
	input wire logic i_flags_write,
	input wire logic [23:0] i_flags_wdata,
	// readback selection and contents of other registers
	input wire logic [4:0] i_readback_select,
	input wire logic [23:0] i_other_rdata,
	// range bits of the converter configuration
	input wire logic i_config_write,
	input wire logic [3:0] i_range_new,
	input wire logic [3:0] i_range_now,
	// activity from the refresh and slew engines
	input wire logic i_refresh_done,
	input wire logic i_slew_active,
	// fault conditions
	input wire logic i_interdie_link_error,
	input wire logic i_watchdog_timeout_flag,
	input wire logic i_interdie_parity_error,
	input wire logic i_latch_mismatch_flag,
	input wire logic i_fault_pin,
	// diagnostic enables
	input wire logic i_en_link,
	input wire logic i_en_wdog,
	input wire logic i_en_parity,
	input wire logic i_en_latch,
	// outputs
	output logic [23:0] o_digital_fault_flags,
	output logic [23:0] o_readback_word,
	output logic o_refresh_start,
	output logic o_select_reserved
);
	typedef struct packed {
		logic refresh;
		logic [23:0] rdata;
	} ddf_bank_state_t;

	ddf_bank_state_t state;
	ddf_bank_state_t next_state;
	logic [DDF_NSTICKY-1:0] ev;
	logic [DDF_NSTICKY-1:0] upd;
	logic [DDF_NSTICKY-1:0] flag;
	logic [23:0] flags_word;
	logic range_change;

	// flag cell order in ev, upd and flag
	localparam int F_LATCH = 0;
	localparam int F_PARITY = 1;
	localparam int F_WDOG = 2;
	localparam int F_LINK = 3;
	localparam int F_RESET = 4;

	// ------------------------------------------------------------
	// fault events and host updates
	// ------------------------------------------------------------
	// events are gated at the source, so a disabled flag cannot be set
	always_comb begin
		ev = '0;
		ev[F_LINK] = i_interdie_link_error & i_en_link;
		ev[F_WDOG] = i_watchdog_timeout_flag & i_en_wdog;
		ev[F_PARITY] = i_interdie_parity_error & i_en_parity;
		ev[F_LATCH] = i_latch_mismatch_flag & i_en_latch;
	end

	// a written one refreshes a flag to its present condition
	always_comb begin
		upd = '0;
		if (i_flags_write) begin
			upd[F_RESET] = i_flags_wdata[DDF_B_RESET];
			upd[F_LINK] = i_flags_wdata[DDF_B_LINK];
			upd[F_WDOG] = i_flags_wdata[DDF_B_WDOG];
			upd[F_PARITY] = i_flags_wdata[DDF_B_PARITY];
			upd[F_LATCH] = i_flags_wdata[DDF_B_LATCH];
		end
	end

	// ------------------------------------------------------------
	// sticky flag cells
	// ------------------------------------------------------------
	// the reset flag has no event: only a reset sets it
	ddf_sticky #(
		.RESET_VALUE(DDF_FLAGS_RESET[DDF_B_RESET])
	) u_flag_reset (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_event(ev[F_RESET]),
		.i_update(upd[F_RESET]),
		.o_flag(flag[F_RESET])
	);

	ddf_sticky #(
		.RESET_VALUE(DDF_FLAGS_RESET[DDF_B_LINK])
	) u_flag_link (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_event(ev[F_LINK]),
		.i_update(upd[F_LINK]),
		.o_flag(flag[F_LINK])
	);

	ddf_sticky #(
		.RESET_VALUE(DDF_FLAGS_RESET[DDF_B_WDOG])
	) u_flag_wdog (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_event(ev[F_WDOG]),
		.i_update(upd[F_WDOG]),
		.o_flag(flag[F_WDOG])
	);

	ddf_sticky #(
		.RESET_VALUE(DDF_FLAGS_RESET[DDF_B_PARITY])
	) u_flag_parity (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_event(ev[F_PARITY]),
		.i_update(upd[F_PARITY]),
		.o_flag(flag[F_PARITY])
	);

	ddf_sticky #(
		.RESET_VALUE(DDF_FLAGS_RESET[DDF_B_LATCH])
	) u_flag_latch (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_event(ev[F_LATCH]),
		.i_update(upd[F_LATCH]),
		.o_flag(flag[F_LATCH])
	);

	// ------------------------------------------------------------
	// word assembly
	// ------------------------------------------------------------
	// a write of the same range leaves the calibration untouched
	assign range_change = i_config_write && (i_range_new != i_range_now);
	assign o_refresh_start = range_change;

	always_comb begin
		flags_word = '0;
		flags_word[DDF_B_PIN] = ~i_fault_pin;
		flags_word[DDF_B_ADDR_LO +: DDF_ADDR_W] = DDF_SEL_FLAGS;
		flags_word[DDF_B_REFRESH] = state.refresh;
		flags_word[DDF_B_SLEW] = i_slew_active;
		// gating on read hides a held flag while its enable is off
		flags_word[DDF_B_RESET] = flag[F_RESET];
		flags_word[DDF_B_LINK] = flag[F_LINK] & i_en_link;
		flags_word[DDF_B_WDOG] = flag[F_WDOG] & i_en_wdog;
		flags_word[DDF_B_PARITY] = flag[F_PARITY] & i_en_parity;
		flags_word[DDF_B_LATCH] = flag[F_LATCH] & i_en_latch;
	end

	// ------------------------------------------------------------
	// refresh flag and readback register
	// ------------------------------------------------------------
	// a range write that meets the end of a refresh starts a new one,
	// so the new range is never reported as refreshed
	always_comb begin
		next_state = state;
		if (range_change)
			next_state.refresh = 1'h1;
		else if (i_refresh_done)
			next_state.refresh = 1'h0;
		if (i_readback_select == DDF_SEL_FLAGS)
			next_state.rdata = flags_word;
		else begin
			// reserved codes also land here and are only flagged
			next_state.rdata = i_other_rdata;
			next_state.rdata[DDF_B_ADDR_LO +: DDF_ADDR_W] =
				i_readback_select;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			state.refresh <= DDF_FLAGS_RESET[DDF_B_REFRESH];
			state.rdata <= DDF_FLAGS_RESET;
		end else
			state <= next_state;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_digital_fault_flags = flags_word;
	assign o_readback_word = state.rdata;
	assign o_select_reserved = (i_readback_select >= DDF_SEL_RSV_LO) &&
		(i_readback_select <= DDF_SEL_RSV_HI);
endmodule

// file: core/ddf_pkg.sv
/*
 digital fault flag register: constants for readback selection codes,
 field positions and reset values.
 assumes: used by the flag bank and the testbench.
*/
package ddf_pkg;
	localparam int DDF_DATA_W = 24;
	localparam int DDF_ADDR_W = 5;
	// readback selection codes
	localparam logic [4:0] DDF_SEL_FIRST = 5'h05;
	localparam logic [4:0] DDF_SEL_LAST = 5'h18;
	localparam logic [4:0] DDF_SEL_RSV_LO = 5'h19;
	localparam logic [4:0] DDF_SEL_RSV_HI = 5'h1B;
	localparam logic [4:0] DDF_SEL_ID3 = 5'h1C;
	localparam logic [4:0] DDF_SEL_DIAG_EN = 5'h10;
	localparam logic [4:0] DDF_SEL_FLAGS = 5'h14;
	// field positions
	localparam int DDF_B_PIN = 21;
	localparam int DDF_B_ADDR_LO = 16;
	localparam int DDF_B_REFRESH = 15;
	localparam int DDF_B_SLEW = 14;
	localparam int DDF_B_RESET = 13;
	localparam int DDF_B_LINK = 12;
	localparam int DDF_B_WDOG = 11;
	localparam int DDF_B_PARITY = 9;
	localparam int DDF_B_LATCH = 8;
	localparam logic [23:0] DDF_FLAGS_RESET = 24'h14A000;
	localparam int DDF_NSTICKY = 5;
endpackage

// file: core/ddf_sticky.sv
/*
 one sticky flag: set by its event, refreshed to the present condition
 when the host writes a one to it.
 assumes: synchronous active-low reset, single clock.
*/
`timescale 1ns/1ns
module ddf_sticky #(
	parameter logic RESET_VALUE = 1'b0
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// condition and host update
	input wire logic i_event,
	input wire logic i_update,
	// flag
	output logic o_flag
);
	typedef struct packed {
		logic flag;
	} ddf_sticky_state_t;

	ddf_sticky_state_t state;
	ddf_sticky_state_t next_state;

	always_comb begin
		next_state = state;
		if (i_update)
			next_state.flag = i_event;
		else if (i_event)
			next_state.flag = 1'b1;
	end

	always_ff @(posedge i_clock) begin
		if (!i_nrst)
			state <= '{flag: RESET_VALUE};
		else
			state <= next_state;
	end

	assign o_flag = state.flag;
endmodule

// file: verif/ddf_flag_bank_monitor.sv
/* checker for the fault flag word and refresh start.
 assumes: bound to ddf_flag_bank, single clock. */
`timescale 1ns/1ns
module ddf_flag_bank_monitor (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// watched inputs
	input wire logic i_fault_pin,
	input wire logic i_slew_active,
	input wire logic i_config_write,
	input wire logic [3:0] i_range_new,
	input wire logic [3:0] i_range_now,
	input wire logic i_refresh_done,
	input wire logic i_en_link,
	input wire logic i_interdie_link_error,
	// watched outputs
	input wire logic [23:0] o_digital_fault_flags,
	input wire logic o_refresh_start
);
	wire logic [23:0] f = o_digital_fault_flags;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	a_pin_status: assert property (f[21] == !i_fault_pin)
		else $error("pin status bit wrong");
	a_slew_live: assert property (f[14] == i_slew_active)
		else $error("slew bit wrong");
	a_addr_field: assert property (f[20:16] == 5'h14)
		else $error("address field wrong");
	a_reset_value: assert property ($rose(i_nrst) |-> f[15] && f[13])
		else $error("reset value wrong");
	a_range_start: assert property (i_config_write &&
		i_range_new != i_range_now |-> o_refresh_start)
		else $error("refresh not started");
	a_refresh_pend: assert property (o_refresh_start |=> f[15])
		else $error("refresh flag not set");
	a_refresh_clr: assert property (i_refresh_done &&
		!o_refresh_start |=> !f[15]) else $error("refresh flag kept");
	a_link_latch: assert property (i_en_link &&
		i_interdie_link_error |=> f[12]) else $error("link flag missed");
	a_link_gate: assert property (!i_en_link |-> !f[12])
		else $error("disabled flag set");
	cover property (o_refresh_start);
	cover property (i_en_link && i_interdie_link_error);
	cover property (i_refresh_done);
endmodule
bind ddf_flag_bank ddf_flag_bank_monitor u_mon (.*);

// file: verif/ddf_host.sv
/* host side model: registers a write request into a strobe one clock later.
 assumes: shares i_clock with the flag bank. */
`timescale 1ns/1ns
module ddf_host (
	// clock
	input wire logic i_clock,
	// write request from the tests
	input wire logic i_req,
	input wire logic [23:0] i_data,
	// strobe and data to the flag bank
	output logic o_flags_write,
	output logic [23:0] o_flags_wdata
);
	always_ff @(posedge i_clock) begin
		o_flags_write <= i_req;
		o_flags_wdata <= i_data;
	end
endmodule

// file: verif/testbench.sv
/* bench for the fault flag bank: writes, fault events, readback.
 assumes: ddf_host makes the write strobe. */
`timescale 1ns/1ns
module testbench;
	import ddf_pkg::*;
	logic i_clock = 0, i_nrst = 0, req = 0, cfg = 0, done = 0;
	logic slew = 0, pin = 1, fw, rs, rsv;
	logic [3:0] ev = 0, en = 4'hF, rn = 4'h0, rnow = 4'h0;
	logic [4:0] sel = 0;
	logic [23:0] wd = 0, oth = 24'hA5A5A5, fl, rb, fwd;
	int err_total = 0, checks = 0;
	int bn[4] = '{DDF_B_LINK, DDF_B_WDOG, DDF_B_PARITY, DDF_B_LATCH};
	always #2 i_clock = ~i_clock;
	ddf_host host (.i_clock(i_clock), .i_req(req), .i_data(wd),
		.o_flags_write(fw), .o_flags_wdata(fwd));
	ddf_flag_bank dut (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_flags_write(fw), .i_flags_wdata(fwd), .i_readback_select(sel),
		.i_other_rdata(oth), .i_config_write(cfg), .i_range_new(rn),
		.i_range_now(rnow), .i_refresh_done(done), .i_slew_active(slew),
		.i_interdie_link_error(ev[0]), .i_watchdog_timeout_flag(ev[1]),
		.i_interdie_parity_error(ev[2]), .i_latch_mismatch_flag(ev[3]),
		.i_fault_pin(pin), .i_en_link(en[0]), .i_en_wdog(en[1]),
		.i_en_parity(en[2]), .i_en_latch(en[3]), .o_digital_fault_flags(fl),
		.o_readback_word(rb), .o_refresh_start(rs), .o_select_reserved(rsv));
	task tick(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	task chk(input string nm, input logic [23:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [23:0] d);
		tick(1); req <= 1; wd <= d;
		tick(1); req <= 0;
		tick(3); #1;
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#20000 err_total++;
		wrap_up();
	end
	initial begin
		tick(6); i_nrst <= 1;
		#1 chk("rb_reset", rb, DDF_FLAGS_RESET);
		tick(2); #1 chk("reset", fl, DDF_FLAGS_RESET);
		wr(24'h002000); chk("rst_clr", fl, 24'h148000);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			tick(1); ev[k] <= 1;
			tick(1); ev[k] <= 0;
			tick(3);
			#1 chk("set", 24'(fl[bn[k]]), 24'h1);
			tick(1); en[k] <= 0;
			#1 chk("hidden", 24'(fl[bn[k]]), 24'h0);
			tick(1); en[k] <= 1;
			#1 chk("held", 24'(fl[bn[k]]), 24'h1);
			tick(1); ev[k] <= 1;
			wr(24'(1 << bn[k]));
			chk("kept", 24'(fl[bn[k]]), 24'h1);
			tick(1); ev[k] <= 0;
			wr(24'(1 << bn[k]));
			chk("clr", 24'(fl[bn[k]]), 24'h0);
			tick(1); en[k] <= 0; ev[k] <= 1;
			tick(3); #1 chk("off", 24'(fl[bn[k]]), 24'h0);
			tick(1); en[k] <= 1; ev[k] <= 0;
			#1 chk("masked", 24'(fl[bn[k]]), 24'h0);
		end
		$display("test sticky done");
		tick(1); done <= 1;
		tick(1); done <= 0;
		tick(1); #1 chk("fresh", 24'(fl[15]), 24'h0);
		tick(1); cfg <= 1;
		#1 chk("same", 24'(rs), 24'h0);
		tick(1); rn <= 4'h3; done <= 1;
		#1 chk("start", 24'(rs), 24'h1);
		tick(1); cfg <= 0; done <= 0;
		tick(1); #1 chk("pend", 24'(fl[15]), 24'h1);
		tick(1); rnow <= 4'h3; cfg <= 1;
		#1 chk("same_now", 24'(rs), 24'h0);
		tick(1); cfg <= 0; done <= 1;
		tick(1); done <= 0;
		#1 chk("cleared", 24'(fl[15]), 24'h0);
		$display("test refresh done");
		tick(1); slew <= 1; pin <= 0;
		#1 chk("live", fl & 24'h204000, 24'h204000);
		tick(1); slew <= 0; pin <= 1;
		#1 chk("idle", fl & 24'h204000, 24'h0);
		$display("test live done");
		for (int c = 5; c < 29; c++) begin
			tick(1); sel <= 5'(c);
			tick(2); #1 chk("rb", rb, (c == 20) ? 24'h140000 :
				{oth[23:21], 5'(c), oth[15:0]});
			chk("rsv", 24'(rsv), 24'(c > 24 && c < 28));
		end
		$display("test readback done");
		tick(1); i_nrst <= 0;
		tick(2); i_nrst <= 1;
		#1 chk("rb_again", rb, DDF_FLAGS_RESET);
		tick(1); #1 chk("reset_again", fl, DDF_FLAGS_RESET);
		$display("test reset again done");
		wrap_up();
	end
endmodule
